// ---- src/pmd_pkg.sv ----
package pmd_pkg;
  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_MISS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_PEND = 4'hC;
  localparam int CFG_WRAP_LSB = 0;
  localparam int CFG_MODE_LSB = 6;
  localparam int CFG_ANYPH_BIT = 8;
  localparam logic [5:0] WRAP_RESET = 6'h3F;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // ************************************************************
  // protocol constants
  // ************************************************************
  localparam int ADDR_N = 16;
  localparam int CHARS_PER_WORD = 3;
  localparam logic [2:0] VEC_SHORT_INSTR = 3'h1;
  localparam logic [2:0] VEC_SHORT_MSG = 3'h2;
  localparam logic [2:0] VEC_NUMERIC = 3'h3;
  localparam logic [2:0] VEC_NUM_SPECIAL = 3'h4;
  localparam logic [2:0] VEC_ALPHA = 3'h5;
  localparam logic [2:0] VEC_NUM_HEX = 3'h7;
  localparam logic [1:0] MTYPE_ZERO = 2'h0;
  localparam logic [2:0] ITYPE_ZERO = 3'h0;
  localparam logic [6:0] CHR_ETX = 7'h03;
  localparam logic [6:0] CHR_LF = 7'h0A;
  localparam logic [6:0] CHR_CR = 7'h0D;
  localparam logic [6:0] CHR_SP = 7'h20;
  localparam logic [6:0] CHR_DEL = 7'h7F;
  // ************************************************************
  // timing
  // ************************************************************
  localparam longint CLOCK_HZ = 200000000;
  localparam int HOLD_MINUTES = 4;
  localparam logic [8:0] HOLD_SECONDS = 9'(HOLD_MINUTES * 60);
  localparam longint SECOND_CYCLES = CLOCK_HZ;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_1600_2L = 2'h0,
    MODE_3200_2L = 2'h1,
    MODE_3200_4L = 2'h2,
    MODE_6400_4L = 2'h3
  } pmd_mode_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [2:0] vector_type_field;
    logic [1:0] message_type_field;
    logic [2:0] instruction_type_field;
    logic retrieval;
    logic temp_group;
    logic [5:0] msg_num;
    logic cont;
    logic first_frag;
  } pmd_hdr_t;
  typedef struct packed {
    logic [6:0] code;
    logic printable;
    logic control;
    logic end_text;
  } pmd_char_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [5:0] first_missing;
    logic [5:0] last_missing;
  } pmd_miss_t;
endpackage : pmd_pkg

// ---- src/pmd_decoder.sv ----
// How it works
// - wrap value of message numbers comes from the configuration register
// - out-of-order number reports the missing number range for retrieval
// - messages with retrieval flag 0 skip the sequence check
// - continuing fragments are joined by matching address and number
// - each 7-bit field of a character word is an ASCII code
// - numeric vectors 011 100 111 are never fragmented
// - pending fragment state is held at least four minutes
// - temporary group messages skip missed-message checking
// - vector 010 with message type 00 is accepted with numeric
// - alpha implies 011, 010; any-phase also accepts 001 type 000
// - four rate and modulation modes are selectable by software
// - unacted control characters take no display space but are kept
// - continuation set means more fragments; clear marks the last
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
module pmd_decoder #(
  parameter longint SEC_CYCLES = pmd_pkg::SECOND_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_hdr_valid,
  input wire pmd_pkg::pmd_hdr_t i_hdr,
  output logic o_hdr_ready,
  input wire logic i_word_valid,
  input wire logic [20:0] i_word,
  input wire logic i_word_last,
  output logic o_word_ready,
  output pmd_pkg::pmd_char_t o_char,
  output logic o_char_valid,
  output logic o_msg_done,
  output logic o_msg_final,
  output logic [3:0] o_msg_addr,
  output logic [5:0] o_msg_num,
  output logic o_missed_valid,
  output pmd_pkg::pmd_miss_t o_missed,
  output pmd_pkg::pmd_mode_t o_link_mode
);
  import pmd_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BODY = 3'b010,
    ST_EMIT = 3'b100
  } pmd_state_t;

  pmd_state_t state_reg, state_next;
  logic [5:0] wrap_reg, wrap_next;
  pmd_mode_t mode_reg, mode_next;
  logic anyph_reg, anyph_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] cnt_miss_reg, cnt_miss_next;
  logic [7:0] cnt_drop_reg, cnt_drop_next;
  logic [7:0] cnt_unsup_reg, cnt_unsup_next;
  logic [7:0] cnt_err_reg, cnt_err_next;
  pmd_miss_t miss_reg, miss_next;
  logic miss_v_reg, miss_v_next;
  logic [5:0] last_reg [ADDR_N];
  logic [5:0] last_next [ADDR_N];
  logic [5:0] pnum_reg [ADDR_N];
  logic [5:0] pnum_next [ADDR_N];
  logic [8:0] age_reg [ADDR_N];
  logic [8:0] age_next [ADDR_N];
  logic [ADDR_N-1:0] seen_reg, seen_next;
  logic [ADDR_N-1:0] pend_reg, pend_next;
  logic [63:0] sec_reg, sec_next;
  pmd_hdr_t hdr_reg, hdr_next;
  logic keep_reg, keep_next;
  logic final_reg, final_next;
  logic [20:0] word_reg, word_next;
  logic wlast_reg, wlast_next;
  logic [1:0] idx_reg, idx_next;
  pmd_char_t char_reg, char_next;
  logic char_v_reg, char_v_next;
  logic done_reg, done_next;

  logic sec_tick;
  logic supported;
  logic numeric_vec;
  logic [5:0] expected;
  logic [6:0] code;

  assign sec_tick = (sec_reg == 64'(SEC_CYCLES - 1));
  assign o_hdr_ready = (state_reg == ST_IDLE);
  assign o_word_ready = (state_reg == ST_BODY);

  // ************************************************************
  // header classification
  // ************************************************************
  always_comb begin
    numeric_vec = (i_hdr.vector_type_field == VEC_NUMERIC) ||
                  (i_hdr.vector_type_field == VEC_NUM_SPECIAL) ||
                  (i_hdr.vector_type_field == VEC_NUM_HEX);
    supported = 1'b0;
    case (i_hdr.vector_type_field)
      VEC_NUMERIC, VEC_NUM_SPECIAL, VEC_NUM_HEX, VEC_ALPHA: begin
        supported = 1'b1;
      end
      VEC_SHORT_MSG: begin
        supported = (i_hdr.message_type_field == MTYPE_ZERO);
      end
      VEC_SHORT_INSTR: begin
        supported = anyph_reg &&
                    (i_hdr.instruction_type_field == ITYPE_ZERO);
      end
      default: begin
        supported = 1'b0;
      end
    endcase
    expected = (last_reg[i_hdr.addr] >= wrap_reg) ? 6'h00 :
               6'(last_reg[i_hdr.addr] + 6'h01);
    code = word_reg[idx_reg*7 +: 7];
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    wrap_next = wrap_reg;
    mode_next = mode_reg;
    anyph_next = anyph_reg;
    rdata_next = 32'h0000_0000;
    cnt_miss_next = cnt_miss_reg;
    cnt_drop_next = cnt_drop_reg;
    cnt_unsup_next = cnt_unsup_reg;
    cnt_err_next = cnt_err_reg;
    miss_next = miss_reg;
    miss_v_next = 1'b0;
    last_next = last_reg;
    pnum_next = pnum_reg;
    age_next = age_reg;
    seen_next = seen_reg;
    pend_next = pend_reg;
    sec_next = sec_tick ? 64'h0 : sec_reg + 64'h1;
    hdr_next = hdr_reg;
    keep_next = keep_reg;
    final_next = final_reg;
    word_next = word_reg;
    wlast_next = wlast_reg;
    idx_next = idx_reg;
    char_next = char_reg;
    char_v_next = 1'b0;
    done_next = 1'b0;

    // pending fragment ageing
    for (int a = 0; a < ADDR_N; a++) begin
      if (pend_reg[a] && sec_tick) begin
        if (age_reg[a] >= HOLD_SECONDS) begin
          pend_next[a] = 1'b0;
          cnt_drop_next = cnt_drop_next + 8'h01;
        end else begin
          age_next[a] = age_reg[a] + 9'h001;
        end
      end
    end

    if (i_wr && (i_addr == REG_CFG)) begin
      wrap_next = i_wdata[CFG_WRAP_LSB +: 6];
      mode_next = pmd_mode_t'(i_wdata[CFG_MODE_LSB +: 2]);
      anyph_next = i_wdata[CFG_ANYPH_BIT];
    end
    if (i_wr && (i_addr == REG_COUNT)) begin
      cnt_miss_next = 8'h00;
      cnt_drop_next = 8'h00;
      cnt_unsup_next = 8'h00;
      cnt_err_next = 8'h00;
    end
    if (i_rd) begin
      case (i_addr)
        REG_CFG: begin
          rdata_next = {23'h0, anyph_reg, mode_reg, wrap_reg};
        end
        REG_MISS: begin
          rdata_next = {16'h0, miss_reg};
        end
        REG_COUNT: begin
          rdata_next = {cnt_err_reg, cnt_unsup_reg, cnt_drop_reg,
                        cnt_miss_reg};
        end
        REG_PEND: begin
          rdata_next = {16'h0, pend_reg};
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end

    case (state_reg)
      ST_IDLE: begin
        if (i_hdr_valid) begin
          hdr_next = i_hdr;
          keep_next = 1'b0;
          final_next = !i_hdr.cont;
          state_next = ST_BODY;
          if (!supported) begin
            cnt_unsup_next = cnt_unsup_next + 8'h01;
          end else if (i_hdr.first_frag) begin
            keep_next = 1'b1;
            if (numeric_vec && i_hdr.cont) begin
              final_next = 1'b1;
              cnt_err_next = cnt_err_next + 8'h01;
            end
            if (i_hdr.retrieval && !i_hdr.temp_group) begin
              if (seen_reg[i_hdr.addr] && (i_hdr.msg_num != expected)) begin
                miss_v_next = 1'b1;
                miss_next.addr = i_hdr.addr;
                miss_next.first_missing = expected;
                miss_next.last_missing = (i_hdr.msg_num == 6'h00) ?
                  wrap_reg : 6'(i_hdr.msg_num - 6'h01);
                cnt_miss_next = cnt_miss_next + 8'h01;
              end
              seen_next[i_hdr.addr] = 1'b1;
              last_next[i_hdr.addr] = i_hdr.msg_num;
            end
          end else if (pend_reg[i_hdr.addr] &&
                       (pnum_reg[i_hdr.addr] == i_hdr.msg_num)) begin
            keep_next = 1'b1;
          end else begin
            cnt_err_next = cnt_err_next + 8'h01;
          end
          if (keep_next) begin
            pend_next[i_hdr.addr] = !final_next;
            pnum_next[i_hdr.addr] = i_hdr.msg_num;
            age_next[i_hdr.addr] = 9'h000;
          end
        end
      end
      ST_BODY: begin
        if (i_word_valid) begin
          word_next = i_word;
          wlast_next = i_word_last;
          idx_next = 2'h0;
          state_next = ST_EMIT;
        end
      end
      ST_EMIT: begin
        char_v_next = keep_reg;
        char_next.code = code;
        char_next.end_text = (code == CHR_ETX);
        char_next.printable = (code >= CHR_SP) && (code != CHR_DEL);
        char_next.control = (code < CHR_SP) || (code == CHR_DEL);
        if (idx_reg == 2'(CHARS_PER_WORD - 1)) begin
          if (wlast_reg) begin
            done_next = keep_reg;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_BODY;
          end
        end else begin
          idx_next = idx_reg + 2'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      wrap_reg <= WRAP_RESET;
      mode_reg <= pmd_mode_t'(MODE_RESET);
      anyph_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      cnt_miss_reg <= 8'h00;
      cnt_drop_reg <= 8'h00;
      cnt_unsup_reg <= 8'h00;
      cnt_err_reg <= 8'h00;
      miss_reg <= '0;
      miss_v_reg <= 1'b0;
      for (int a = 0; a < ADDR_N; a++) begin
        last_reg[a] <= 6'h00;
        pnum_reg[a] <= 6'h00;
        age_reg[a] <= 9'h000;
      end
      seen_reg <= '0;
      pend_reg <= '0;
      sec_reg <= 64'h0;
      hdr_reg <= '0;
      keep_reg <= 1'b0;
      final_reg <= 1'b0;
      word_reg <= 21'h000000;
      wlast_reg <= 1'b0;
      idx_reg <= 2'h0;
      char_reg <= '0;
      char_v_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wrap_reg <= wrap_next;
      mode_reg <= mode_next;
      anyph_reg <= anyph_next;
      rdata_reg <= rdata_next;
      cnt_miss_reg <= cnt_miss_next;
      cnt_drop_reg <= cnt_drop_next;
      cnt_unsup_reg <= cnt_unsup_next;
      cnt_err_reg <= cnt_err_next;
      miss_reg <= miss_next;
      miss_v_reg <= miss_v_next;
      last_reg <= last_next;
      pnum_reg <= pnum_next;
      age_reg <= age_next;
      seen_reg <= seen_next;
      pend_reg <= pend_next;
      sec_reg <= sec_next;
      hdr_reg <= hdr_next;
      keep_reg <= keep_next;
      final_reg <= final_next;
      word_reg <= word_next;
      wlast_reg <= wlast_next;
      idx_reg <= idx_next;
      char_reg <= char_next;
      char_v_reg <= char_v_next;
      done_reg <= done_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_char = char_reg;
  assign o_char_valid = char_v_reg;
  assign o_msg_done = done_reg;
  assign o_msg_final = final_reg;
  assign o_msg_addr = hdr_reg.addr;
  assign o_msg_num = hdr_reg.msg_num;
  assign o_missed_valid = miss_v_reg;
  assign o_missed = miss_reg;
  assign o_link_mode = mode_reg;
endmodule : pmd_decoder

// ---- test/pmd_decoder_monitor.sv ----
module pmd_decoder_monitor
  import pmd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_hdr_valid,
  input wire pmd_pkg::pmd_hdr_t i_hdr,
  input wire logic o_hdr_ready,
  input wire logic i_word_valid,
  input wire logic [20:0] i_word,
  input wire logic i_word_last,
  input wire logic o_word_ready,
  input wire pmd_pkg::pmd_char_t o_char,
  input wire logic o_char_valid,
  input wire logic o_msg_done,
  input wire logic o_msg_final,
  input wire logic [3:0] o_msg_addr,
  input wire logic [5:0] o_msg_num,
  input wire logic o_missed_valid,
  input wire pmd_pkg::pmd_miss_t o_missed,
  input wire pmd_pkg::pmd_mode_t o_link_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  logic take;
  assign take = i_hdr_valid && o_hdr_ready;
  AST_CFG_MODE: assert property (i_wr && i_addr == REG_CFG
    |=> o_link_mode == $past(i_wdata[7:6]))
    else $error("link mode not taken from write");
  AST_CFG_WRAP: assert property (i_wr && i_addr == REG_CFG ##1
    !i_wr ##1 i_rd && i_addr == REG_CFG
    |=> o_rdata[5:0] == $past(i_wdata[5:0], 3))
    else $error("wrap readback wrong");
  AST_PRINT: assert property (o_char_valid |->
    o_char.printable == (o_char.code >= CHR_SP && o_char.code < CHR_DEL)
    && o_char.control != o_char.printable)
    else $error("char class wrong");
  AST_ETX: assert property (o_char_valid |->
    o_char.end_text == (o_char.code == CHR_ETX))
    else $error("end text flag wrong");
  AST_BURST: assert property ($rose(o_char_valid) |->
    o_char_valid [*3] ##1 !o_char_valid)
    else $error("char burst not three");
  AST_DONE: assert property (o_msg_done |->
    o_char_valid && $past(o_char_valid) && o_hdr_ready)
    else $error("done misplaced");
  AST_MISS_CAUSE: assert property (o_missed_valid |->
    $past(take && i_hdr.first_frag) && o_missed.addr == $past(i_hdr.addr))
    else $error("miss without header");
  AST_NO_RET: assert property (take && !i_hdr.retrieval
    |=> !o_missed_valid)
    else $error("miss on unnumbered");
  AST_NO_TEMP: assert property (take && i_hdr.temp_group
    |=> !o_missed_valid)
    else $error("miss on temp group");
  AST_GAP: assert property (o_missed_valid && o_msg_num != 6'h0
    |-> o_missed.last_missing == o_msg_num - 6'h1)
    else $error("last missing wrong");
  AST_EXCL: assert property (!(o_hdr_ready && o_word_ready))
    else $error("both readies high");
  cover property (o_missed_valid);
  cover property (o_msg_done && o_msg_final);
  cover property (o_char_valid && o_char.control);
endmodule : pmd_decoder_monitor

bind pmd_decoder pmd_decoder_monitor mon (.*);

// ---- test/pmd_encoder_model.sv ----
module pmd_encoder_model
  import pmd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_hdr_ready,
  input wire logic i_word_ready,
  output logic o_hdr_valid = 1'b0,
  output pmd_pkg::pmd_hdr_t o_hdr = '0,
  output logic o_word_valid = 1'b0,
  output logic [20:0] o_word = 21'h0,
  output logic o_word_last = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // one header, one last word; released lines show inverse
  // ************************************************************
  task automatic send(input pmd_hdr_t h, input logic [20:0] w,
      input int gap);
    repeat (gap) @(posedge i_clock);
    o_hdr_valid <= 1'b1;
    o_hdr <= h;
    do @(posedge i_clock); while (!i_hdr_ready);
    o_hdr_valid <= 1'b0;
    o_hdr <= pmd_hdr_t'(~h);
    o_word_valid <= 1'b1;
    o_word <= w;
    o_word_last <= 1'b1;
    do @(posedge i_clock); while (!i_word_ready);
    o_word_valid <= 1'b0;
    o_word <= ~w;
    o_word_last <= 1'b0;
  endtask : send
endmodule : pmd_encoder_model

// ---- test/paging_message_decoder_tb.sv ----
module paging_message_decoder_tb import pmd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic i_hdr_valid, o_hdr_ready, i_word_valid, i_word_last;
  logic o_word_ready, o_char_valid, o_msg_done, o_msg_final;
  logic o_missed_valid;
  logic [20:0] i_word;
  logic [3:0] o_msg_addr;
  logic [5:0] o_msg_num;
  pmd_hdr_t i_hdr, h;
  pmd_char_t o_char;
  pmd_miss_t o_missed;
  pmd_mode_t o_link_mode;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int missed = 0;
  int dones = 0;
  logic [6:0] q[$];
  logic [31:0] d;
  localparam logic [20:0] W = {7'h43, 7'h42, 7'h41};
  localparam logic [20:0] WP = {CHR_ETX, CHR_ETX, 7'h5A};
  localparam logic [20:0] WC = {7'h5A, CHR_LF, 7'h59};
  pmd_decoder #(.SEC_CYCLES(10)) uut (.*);
  pmd_encoder_model enc (.i_clock(i_clock), .i_hdr_ready(o_hdr_ready),
    .i_word_ready(o_word_ready), .o_hdr_valid(i_hdr_valid),
    .o_hdr(i_hdr), .o_word_valid(i_word_valid), .o_word(i_word),
    .o_word_last(i_word_last));
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_char_valid) q.push_back(o_char.code);
    if (o_missed_valid) missed <= missed + 1;
    if (o_msg_done) dones <= dones + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask : rd
  function automatic pmd_hdr_t mk(input logic [3:0] a,
      input logic [2:0] v, input logic [5:0] n, input logic [3:0] f);
    mk = '0;
    mk.addr = a;
    mk.vector_type_field = v;
    mk.msg_num = n;
    {mk.retrieval, mk.temp_group, mk.cont, mk.first_frag} = f;
  endfunction : mk
  task automatic msg(input pmd_hdr_t hh, input logic [20:0] w,
      input logic ok, input int gap);
    int n;
    int d0;
    q.delete();
    d0 = dones;
    enc.send(hh, w, gap);
    repeat (8) @(posedge i_clock);
    n = ok ? 3 : 0;
    chk(q.size(), n);
    for (int i = 0; i < n; i++) chk(q[i], w[7*i+:7]);
    chk(dones - d0, ok);
    chk({o_msg_addr, o_msg_num}, {hh.addr, hh.msg_num});
  endtask : msg
  task automatic test_done();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rd(REG_CFG, d);
    chk(d, 32'h3F);
    for (int m = 0; m < 4; m++) begin
      wr(REG_CFG, 32'((m << 6) | 5));
      chk(o_link_mode, m);
    end
    rd(REG_CFG, d);
    chk(d, 32'hC5);
    wr(REG_CFG, 32'h1C5);
    rd(4'h2, d);
    chk(d, 32'h0);
    msg(mk(1, VEC_ALPHA, 0, 4'b1001), W, 1, 0);
    chk(o_msg_final, 1);
    msg(mk(1, VEC_ALPHA, 3, 4'b1001), W, 1, 3);
    chk(o_missed, {4'h1, 6'h1, 6'h2});
    msg(mk(1, VEC_ALPHA, 1, 4'b0001), W, 1, 0);
    msg(mk(1, VEC_ALPHA, 4, 4'b1001), W, 1, 0);
    msg(mk(1, VEC_ALPHA, 5, 4'b1001), W, 1, 0);
    msg(mk(1, VEC_ALPHA, 0, 4'b1001), W, 1, 0);
    msg(mk(1, VEC_NUMERIC, 2, 4'b0001), WC, 1, 0);
    msg(mk(1, VEC_ALPHA, 9, 4'b1101), W, 1, 0);
    chk(missed, 1);
    rd(REG_COUNT, d);
    chk(d[7:0], 8'h01);
    msg(mk(2, VEC_ALPHA, 7, 4'b1011), W, 1, 0);
    chk(o_msg_final, 0);
    rd(REG_PEND, d);
    chk(d[15:0], 16'h0004);
    msg(mk(2, VEC_ALPHA, 8, 4'b1000), W, 0, 0);
    msg(mk(2, VEC_ALPHA, 7, 4'b1000), WP, 1, 2300);
    chk(o_msg_final, 1);
    msg(mk(3, VEC_ALPHA, 1, 4'b1011), W, 1, 0);
    msg(mk(3, VEC_ALPHA, 1, 4'b1000), W, 0, 2600);
    rd(REG_PEND, d);
    chk(d[15:0], 16'h0);
    msg(mk(4, VEC_NUMERIC, 0, 4'b1011), WC, 1, 0);
    chk(o_msg_final, 1);
    msg(mk(5, VEC_NUM_SPECIAL, 0, 4'b1001), W, 1, 0);
    msg(mk(5, VEC_NUM_HEX, 1, 4'b1001), W, 1, 0);
    h = mk(6, VEC_SHORT_MSG, 0, 4'b0001);
    msg(h, W, 1, 0);
    h.message_type_field = 2'h1;
    msg(h, W, 0, 0);
    h = mk(6, VEC_SHORT_INSTR, 0, 4'b0001);
    msg(h, W, 1, 0);
    h.instruction_type_field = 3'h1;
    msg(h, W, 0, 0);
    msg(mk(6, 3'h6, 0, 4'b0001), W, 0, 0);
    wr(REG_CFG, 32'hC5);
    msg(mk(6, VEC_SHORT_INSTR, 0, 4'b0001), W, 0, 0);
    chk(missed, 1);
    rd(REG_COUNT, d);
    chk(d, 32'h0304_0101);
    wr(REG_COUNT, 32'h0);
    rd(REG_COUNT, d);
    chk(d, 32'h0);
    test_done();
  end
endmodule : paging_message_decoder_tb
